/* cca_pkg.sv */
package cca_pkg;
   localparam int NUM_MODULES = 5;
   localparam int CNT_W = 16;
   // Register byte addresses on the bus.
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_AMODE = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   localparam logic [7:0] ADDR_GLOBAL = 8'h10;
   localparam logic [7:0] ADDR_ROUTE = 8'h14;
   localparam logic [7:0] MODE_BASE = 8'h20;
   localparam logic [7:0] MODE_STEP = 8'h04;
   localparam logic [7:0] VALUE_BASE = 8'h40;
   localparam logic [7:0] VALUE_STEP = 8'h08;
   localparam logic [7:0] VALUE_HIGH_OFS = 8'h04;
   // Array control register fields.
   localparam int CTL_WRAP = 7;
   localparam int CTL_RUN = 6;
   localparam logic [7:0] FLAG_BITS = 8'h9f;
   // Array mode register fields.
   localparam int MD_IDLE = 7;
   localparam int MD_TB_HI = 2;
   localparam int MD_TB_LO = 1;
   localparam int MD_WRAP_IE = 0;
   localparam logic [7:0] AMODE_BITS = 8'h87;
   // Interrupt controller enables.
   localparam int GL_GLOBAL = 1;
   localparam int GL_ARRAY = 0;
   // Module mode register fields.
   localparam int MM_COMPARE = 6;
   localparam int MM_RISE = 5;
   localparam int MM_FALL = 4;
   localparam int MM_MATCH = 3;
   localparam int MM_TOGGLE = 2;
   localparam int MM_PWM = 1;
   localparam int MM_IRQ = 0;
   localparam logic [7:0] MODE_BITS = 8'h7f;
   // Reset values and timing.
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_TOP = 16'hffff;
   localparam int DIV_LONG = 12;
   localparam int DIV_SHORT = 4;

   typedef enum logic [1:0] {TB_DIV12, TB_DIV4, TB_TIMER0, TB_EXT} cca_tb_t;
   typedef enum logic [2:0] {MK_NONE, MK_CAPTURE, MK_TIMER, MK_HSO, MK_PWM}
      cca_mode_t;
endpackage

/* cca_count_if.sv */
interface cca_count_if;
   import cca_pkg::*;
   logic tick;
   logic moved;
   logic [CNT_W-1:0] count;
   modport source (output tick);
   modport core (input tick, output count, output moved);
   modport sink (input count, input moved);
endinterface

/* cca_timebase.sv */
module cca_timebase
   import cca_pkg::*;
(
   // Clock, reset and freeze.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_en,
   // Selection and sources.
   input wire logic active,
   input cca_tb_t select,
   input wire logic timer0_overflow,
   input wire logic external_count_input,
   // Tick to the counter.
   cca_count_if.source cnt
);
   logic [3:0] pre_reg;
   logic [3:0] pre_next;
   logic [2:0] ext_sync_reg;
   logic tick_reg;
   logic tick_next;

   wire pre_last = pre_reg == 4'(DIV_LONG - 1);
   wire quarter = pre_reg[1:0] == 2'(DIV_SHORT - 1);
   // A falling edge is seen once, from the second and third stages.
   wire ext_fall = ext_sync_reg[2] & ~ext_sync_reg[1];

   assign pre_next = pre_last ? 4'h0 : pre_reg + 4'h1;
   assign cnt.tick = tick_reg;

   always_comb
   begin
      unique case (select)
         TB_DIV12: tick_next = pre_last;
         TB_DIV4: tick_next = quarter;
         TB_TIMER0: tick_next = timer0_overflow;
         TB_EXT: tick_next = ext_fall;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pre_reg <= 4'h0;
         ext_sync_reg <= 3'h0;
         tick_reg <= 1'b0;
      end
      else if (clock_en)
      begin
         ext_sync_reg <= {ext_sync_reg[1:0], external_count_input};
         tick_reg <= tick_next & active;
         if (active)
         begin
            pre_reg <= pre_next;
         end
      end
   end

   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   a_ext_fall_tick: assert property (
      clock_en && active && select == TB_EXT && ext_fall |=> tick_reg)
      else $error("external falling edge gave no tick");

   a_div_four_gap: assert property (
      clock_en && active && select == TB_DIV4 && tick_next
      ##1 clock_en && active && select == TB_DIV4 |-> !tick_next)
      else $error("divide-by-four ticks too close");
endmodule

/* cca_module.sv */
module cca_module
   import cca_pkg::*;
(
   // Clock, reset and freeze.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_en,
   // Control from the register file.
   input wire logic active,
   input wire logic routed,
   input wire logic [7:0] mode,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic [7:0] wr_data,
   // Pin side.
   input wire logic module_line,
   // Shared counter.
   cca_count_if.sink cnt,
   // Results.
   output logic [CNT_W-1:0] value,
   output cca_mode_t kind,
   output logic event_pulse
);
   logic [2:0] line_sync_reg;
   logic [CNT_W-1:0] value_reg;
   logic [CNT_W-1:0] value_next;
   logic event_reg;

   wire rise = line_sync_reg[1] & ~line_sync_reg[2];
   wire fall = ~line_sync_reg[1] & line_sync_reg[2];
   wire edge_en = mode[MM_RISE] | mode[MM_FALL];
   wire no_out = ~mode[MM_TOGGLE] & ~mode[MM_PWM];
   wire capture_mode = edge_en & ~mode[MM_MATCH] & no_out;
   wire timer_mode = mode[MM_COMPARE] & mode[MM_MATCH] & ~edge_en
      & no_out;
   wire hso_mode = mode[MM_COMPARE] & mode[MM_MATCH] & mode[MM_TOGGLE]
      & ~mode[MM_PWM] & ~edge_en;
   wire pwm_mode = mode[MM_COMPARE] & mode[MM_PWM] & ~mode[MM_TOGGLE]
      & ~edge_en;
   wire hit_edge = (mode[MM_RISE] & rise) | (mode[MM_FALL] & fall);
   wire capture = active & routed & capture_mode & hit_edge;
   wire match = active & timer_mode & cnt.moved
      & (cnt.count == value_reg);

   // A capture wins over a byte write in the same cycle.
   assign value_next = capture ? cnt.count :
      {wr_high ? wr_data : value_reg[15:8],
       wr_low ? wr_data : value_reg[7:0]};
   assign kind = capture_mode ? MK_CAPTURE : timer_mode ? MK_TIMER :
      hso_mode ? MK_HSO : pwm_mode ? MK_PWM : MK_NONE;
   assign value = value_reg;
   assign event_pulse = event_reg;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         line_sync_reg <= 3'h0;
         value_reg <= COUNT_RESET;
         event_reg <= 1'b0;
      end
      else if (clock_en)
      begin
         line_sync_reg <= {line_sync_reg[1:0], module_line};
         value_reg <= value_next;
         event_reg <= capture | match;
      end
   end

   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   sequence s_capture;
      clock_en && capture;
   endsequence

   a_capture_load: assert property (
      s_capture |=> value == $past(cnt.count) && event_pulse)
      else $error("capture did not load the counter");

   a_timer_match: assert property (
      clock_en && match |=> event_pulse)
      else $error("compare match gave no event");

   a_quiet_modes: assert property (
      clock_en && !capture_mode && !timer_mode |=> !event_pulse)
      else $error("event outside capture or timer mode");

   a_rise_once: assert property (
      clock_en && rise |=> !rise)
      else $error("one transition seen twice");
endmodule

/* cca_counter_array.sv */
//////////////////////////////////////////////////////////////////////
// Functional notes
// - One shared 16-bit counter feeds five modules, each with 16-bit value.
// - Each module line only acts when its crossbar routing is enabled.
// - Counter advances from one of four selectable timebase sources.
// - Each module picks its own mode: capture, timer, fast output, PWM.
// - Capture needs match, toggle, PWM clear; edge enables pick the edge.
// - Software timer needs compare and match set, edge, toggle and PWM clear.
// - Fast output and PWM are decoded from their enable combinations.
// - A module raises an interrupt only with its own enable set.
// - Interrupts pass only with global and array enables both set.
// - A selected edge copies the whole counter into the module value.
// - Every capture sets the module event flag and may interrupt.
// - Event flags stay set until software writes a one to clear.
// - In timer mode a counter step onto the value sets the flag.
// - Select 00 is /12, 01 is /4, 10 timer 0, 11 falling edges.
// - The counter counts only while run is set, else it holds.
// - Wrap from ffff to 0000 sets the wrap flag, may interrupt.
// - With idle suspend set, the array halts while the core idles.
//////////////////////////////////////////////////////////////////////
module cca_counter_array
   import cca_pkg::*;
(
   // Clock, reset and freeze.
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_en,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Core state and timebase sources.
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic external_count_input,
   // Module lines from the pin crossbar.
   input wire logic [NUM_MODULES-1:0] module_line,
   // Interrupt request.
   output logic irq
);
   cca_count_if cnt ();

   logic ack_reg;
   logic [31:0] dat_reg;
   logic [7:0] flag_reg;
   logic [7:0] flag_next;
   logic run_reg;
   logic [7:0] amode_reg;
   logic [7:0] mask_reg;
   logic [1:0] glob_reg;
   logic [NUM_MODULES-1:0] route_reg;
   logic [7:0] mode_reg [NUM_MODULES];
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic moved_reg;
   logic irq_reg;
   logic irq_next;
   logic [31:0] rd_data;
   logic [31:0] rd_mod [NUM_MODULES];
   logic [CNT_W-1:0] value [NUM_MODULES];
   cca_mode_t kind [NUM_MODULES];
   logic [NUM_MODULES-1:0] mod_event;
   logic [NUM_MODULES-1:0] mod_irq_en;

   ////////////////////////////////////////////////////////////////////
   // Bus decode. A write lands on the edge at which the master sees
   // ack, so it is taken exactly once per transfer.

   wire req = wb_cyc_i & wb_stb_i;
   wire wr = req & wb_we_i & ack_reg;
   wire wr_b0 = wr & wb_sel_i[0];
   wire wr_b1 = wr & wb_sel_i[1];
   wire hit_ctl = wb_adr_i == ADDR_CONTROL;
   wire hit_amode = wb_adr_i == ADDR_AMODE;
   wire hit_count = wb_adr_i == ADDR_COUNT;
   wire hit_mask = wb_adr_i == ADDR_MASK;
   wire hit_glob = wb_adr_i == ADDR_GLOBAL;
   wire hit_route = wb_adr_i == ADDR_ROUTE;
   wire [7:0] ctl_view = {flag_reg[CTL_WRAP], run_reg, flag_reg[5:0]};
   wire [31:0] rd_fixed =
      hit_ctl ? {24'h0, ctl_view} :
      hit_amode ? {24'h0, amode_reg} :
      hit_count ? {16'h0, count_reg} :
      hit_mask ? {24'h0, mask_reg} :
      hit_glob ? {30'h0, glob_reg} :
      hit_route ? {27'h0, route_reg} : 32'h0;

   always_comb
   begin
      rd_data = rd_fixed;
      for (int i = 0; i < NUM_MODULES; i++)
      begin
         rd_data = rd_data | rd_mod[i];
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
      end
      else if (clock_en)
      begin
         ack_reg <= req & ~ack_reg;
         dat_reg <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counter and timebase.

   // Idle suspend freezes the counter, the prescaler and all modules.
   wire halt = amode_reg[MD_IDLE] & cpu_idle;
   wire active = ~halt;
   wire step = cnt.tick & run_reg & active;
   wire wrap = step & (count_reg == COUNT_TOP);
   wire [1:0] tb_bits = {amode_reg[MD_TB_HI], amode_reg[MD_TB_LO]};

   assign count_next = step ? count_reg + 16'h0001 : count_reg;
   assign cnt.count = count_reg;
   assign cnt.moved = moved_reg;

   cca_timebase u_timebase
   (
      .clock (clock),
      .reset_n (reset_n),
      .clock_en (clock_en),
      .active (active),
      .select (cca_tb_t'(tb_bits)),
      .timer0_overflow (timer0_overflow),
      .external_count_input (external_count_input),
      .cnt (cnt)
   );

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_reg <= COUNT_RESET;
         moved_reg <= 1'b0;
      end
      else if (clock_en)
      begin
         count_reg <= count_next;
         moved_reg <= step;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Capture/compare modules, one per line.

   genvar n;
   generate
      for (n = 0; n < NUM_MODULES; n++)
      begin : g_mod
         wire [7:0] lo_addr = VALUE_BASE + 8'(n) * VALUE_STEP;
         wire hit_mode = wb_adr_i == MODE_BASE + 8'(n) * MODE_STEP;
         wire hit_lo = wb_adr_i == lo_addr;
         wire hit_hi = wb_adr_i == lo_addr + VALUE_HIGH_OFS;

         assign mod_irq_en[n] = mode_reg[n][MM_IRQ];
         assign rd_mod[n] =
            hit_mode ? {21'h0, kind[n], mode_reg[n]} :
            hit_lo ? {24'h0, value[n][7:0]} :
            hit_hi ? {24'h0, value[n][15:8]} : 32'h0;

         always_ff @(posedge clock or negedge reset_n)
         begin
            if (!reset_n)
            begin
               mode_reg[n] <= RESET_BYTE;
            end
            else if (clock_en && wr_b0 && hit_mode)
            begin
               mode_reg[n] <= wb_dat_i[7:0] & MODE_BITS;
            end
         end

         cca_module u_mod
         (
            .clock (clock),
            .reset_n (reset_n),
            .clock_en (clock_en),
            .active (active),
            .routed (route_reg[n]),
            .mode (mode_reg[n]),
            .wr_low (wr_b0 & hit_lo),
            .wr_high (wr_b0 & hit_hi),
            .wr_data (wb_dat_i[7:0]),
            .module_line (module_line[n]),
            .cnt (cnt),
            .value (value[n]),
            .kind (kind[n]),
            .event_pulse (mod_event[n])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Control registers, sticky flags and interrupt.

   wire [7:0] events = {wrap, 2'b00, mod_event};
   wire [7:0] clr = (wr_b0 && hit_ctl) ? wb_dat_i[7:0] & FLAG_BITS
      : RESET_BYTE;
   wire [7:0] irq_en = {amode_reg[MD_WRAP_IE], 2'b00, mod_irq_en};
   wire glob_ok = glob_reg[GL_GLOBAL] & glob_reg[GL_ARRAY];
   wire pending = |(flag_reg & mask_reg & irq_en);

   // An event in the clearing cycle survives the clear.
   assign flag_next = (flag_reg & ~clr) | events;
   assign irq_next = glob_ok & pending;
   assign irq = irq_reg;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         flag_reg <= RESET_BYTE;
         irq_reg <= 1'b0;
      end
      else if (clock_en)
      begin
         flag_reg <= flag_next;
         irq_reg <= irq_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         run_reg <= 1'b0;
         amode_reg <= RESET_BYTE;
         mask_reg <= RESET_BYTE;
         glob_reg <= 2'b00;
         route_reg <= '0;
      end
      else if (clock_en && wr_b0)
      begin
         if (hit_ctl)
         begin
            run_reg <= wb_dat_i[CTL_RUN];
         end
         if (hit_amode)
         begin
            amode_reg <= wb_dat_i[7:0] & AMODE_BITS;
         end
         if (hit_mask)
         begin
            mask_reg <= wb_dat_i[7:0] & FLAG_BITS;
         end
         if (hit_glob)
         begin
            glob_reg <= wb_dat_i[1:0];
         end
         if (hit_route)
         begin
            route_reg <= wb_dat_i[NUM_MODULES-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   sequence s_wrap_step;
      clock_en && step && count_reg == COUNT_TOP;
   endsequence

   sequence s_no_clear;
      !(wr_b0 && hit_ctl);
   endsequence

   a_wrap_flag: assert property (
      s_wrap_step |=> flag_reg[CTL_WRAP] && count_reg == COUNT_RESET)
      else $error("wrap did not set the flag");

   a_count_step: assert property (
      clock_en && step |=> count_reg == 16'($past(count_reg) + 16'h0001))
      else $error("counter did not advance by one");

   a_run_hold: assert property (
      clock_en && !run_reg |=> $stable(count_reg))
      else $error("counter moved while stopped");

   a_idle_halt: assert property (
      clock_en && halt |=> $stable(count_reg) && !moved_reg)
      else $error("counter moved while suspended");

   a_flag_sticky: assert property (
      (clock_en && flag_reg[0]) and s_no_clear |=> flag_reg[0])
      else $error("event flag dropped without a clear");

   a_flag_set: assert property (
      clock_en && mod_event[0] |=> flag_reg[0])
      else $error("module event lost");

   a_irq_gate: assert property (
      clock_en && !glob_ok |=> !irq)
      else $error("interrupt passed the global gate");

   a_irq_raise: assert property (
      clock_en && glob_ok && pending |=> irq)
      else $error("enabled pending event gave no interrupt");

   a_irq_quiet: assert property (
      clock_en && !pending |=> !irq)
      else $error("interrupt with nothing enabled pending");

   a_bus_ack: assert property (
      clock_en && req && !ack_reg ##1 clock_en |-> ack_reg ##1 !ack_reg)
      else $error("ack not a single pulse");
endmodule

/* cca_pin_model.sv */
module cca_pin_model
   import cca_pkg::*;
(
   // Clock.
   input wire logic clock,
   // Pins into the array.
   output logic [NUM_MODULES-1:0] module_line,
   output logic external_count_input
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      module_line = '0;
      external_count_input = 1'b1;
   end
   // Levels are held four clocks so the synchroniser cannot miss them.
   task automatic line_to(input int n, input logic lvl);
      @(posedge clock);
      module_line[n] <= lvl;
      repeat (4) @(posedge clock);
   endtask
   // The count input idles high and each pulse is one falling edge.
   task automatic ext_pulses(input int k);
      repeat (k)
      begin
         @(posedge clock);
         external_count_input <= 1'b0;
         repeat (3) @(posedge clock);
         external_count_input <= 1'b1;
         repeat (3) @(posedge clock);
      end
   endtask
endmodule

/* test_counter_array_capture_compare.sv */
module test_counter_array_capture_compare
   import cca_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic cpu_idle = 1'b0;
   logic t0 = 1'b0;
   logic [NUM_MODULES-1:0] line;
   logic ext;
   logic irq;
   logic [31:0] rd;
   int n_errors = 0;
   int n_tests = 0;
   always #50 clock = ~clock;
   cca_pin_model i_pins (.clock(clock), .module_line(line),
      .external_count_input(ext));
   cca_counter_array i_dut (.clock(clock), .reset_n(reset_n),
      .clock_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_idle(cpu_idle),
      .timer0_overflow(t0), .external_count_input(ext),
      .module_line(line), .irq(irq));
   ////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("errors %0d comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      int i;
      @(posedge clock);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      i = 0;
      do
      begin
         @(posedge clock);
         i++;
      end
      while (ack !== 1'b1 && i < 20);
      rd = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1)
      begin
         n_errors++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      wb(1'b0, a, 8'h00);
      chk(rd[15:0], e);
   endtask
   // The interrupt output lags its cause by one registered stage.
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clock);
      chk({15'h0, irq}, {15'h0, e});
   endtask
   task automatic tick(input int k);
      repeat (k)
      begin
         @(posedge clock);
         t0 <= 1'b1;
         @(posedge clock);
         t0 <= 1'b0;
      end
      repeat (3) @(posedge clock);
   endtask
   function automatic logic [7:0] mo(input int n);
      return MODE_BASE + 8'(n) * MODE_STEP;
   endfunction
   function automatic logic [7:0] vl(input int n);
      return VALUE_BASE + 8'(n) * VALUE_STEP;
   endfunction
   ////////////////////////////////////////////////////////////////////
   task automatic s_capture();
      rdchk(ADDR_CONTROL, 16'h0000);
      rdchk(8'h18, 16'h0000);
      wr(ADDR_ROUTE, 8'h05);
      wr(ADDR_MASK, 8'h1f);
      wr(ADDR_GLOBAL, 8'h03);
      wr(ADDR_AMODE, 8'h04);
      wr(ADDR_CONTROL, 8'h40);
      wr(mo(0), 8'h21);
      wr(vl(0) + VALUE_HIGH_OFS, 8'ha5);
      tick(5);
      rdchk(ADDR_COUNT, 16'h0005);
      i_pins.line_to(0, 1'b1);
      rdchk(vl(0), 16'h0005);
      rdchk(vl(0) + VALUE_HIGH_OFS, 16'h0000);
      rdchk(ADDR_CONTROL, 16'h0041);
      irq_is(1'b1);
      wr(ADDR_CONTROL, 8'h41);
      rdchk(ADDR_CONTROL, 16'h0040);
      irq_is(1'b0);
      i_pins.line_to(0, 1'b0);
      rdchk(ADDR_CONTROL, 16'h0040);
   endtask
   task automatic s_compare();
      wr(vl(1), 8'h07);
      wr(mo(1), 8'h48);
      tick(2);
      rdchk(ADDR_CONTROL, 16'h0042);
      irq_is(1'b0);
      wr(mo(1), 8'h49);
      irq_is(1'b1);
      wr(ADDR_GLOBAL, 8'h01);
      irq_is(1'b0);
      wr(ADDR_GLOBAL, 8'h02);
      irq_is(1'b0);
      wr(ADDR_GLOBAL, 8'h03);
      irq_is(1'b1);
      wr(ADDR_CONTROL, 8'h5f);
      irq_is(1'b0);
   endtask
   task automatic s_idle_run();
      wr(ADDR_AMODE, 8'h84);
      @(posedge clock);
      cpu_idle <= 1'b1;
      tick(3);
      rdchk(ADDR_COUNT, 16'h0007);
      wr(ADDR_AMODE, 8'h04);
      tick(1);
      rdchk(ADDR_COUNT, 16'h0008);
      @(posedge clock);
      cpu_idle <= 1'b0;
      wr(ADDR_CONTROL, 8'h00);
      tick(2);
      rdchk(ADDR_COUNT, 16'h0008);
      wr(ADDR_CONTROL, 8'h40);
      wr(ADDR_AMODE, 8'h06);
      i_pins.ext_pulses(3);
      rdchk(ADDR_COUNT, 16'h000b);
   endtask
   task automatic s_edges();
      wr(mo(2), 8'h10);
      wr(mo(3), 8'h30);
      i_pins.line_to(2, 1'b1);
      i_pins.line_to(3, 1'b1);
      rdchk(ADDR_CONTROL, 16'h0040);
      i_pins.line_to(2, 1'b0);
      rdchk(ADDR_CONTROL, 16'h0044);
      rdchk(vl(2), 16'h000b);
      wr(ADDR_ROUTE, 8'h0d);
      i_pins.line_to(3, 1'b0);
      rdchk(ADDR_CONTROL, 16'h004c);
      wr(ADDR_CONTROL, 8'h5f);
   endtask
   // Prescaler phase is unknown, so one step of slack is allowed.
   task automatic s_rates();
      int d;
      int div;
      logic [15:0] a;
      logic [15:0] delta;
      for (d = 0; d < 2; d++)
      begin
         div = d ? DIV_SHORT : DIV_LONG;
         wr(ADDR_AMODE, {6'h00, d[0], 1'b0});
         wb(1'b0, ADDR_COUNT, 8'h00);
         a = rd[15:0];
         repeat (10 * div) @(posedge clock);
         wb(1'b0, ADDR_COUNT, 8'h00);
         delta = rd[15:0] - a;
         chk({15'h0, delta == 10 || delta == 11}, 16'h0001);
      end
   endtask
   task automatic s_modes();
      logic [7:0] m[9] = '{8'h20, 8'h10, 8'h30, 8'h60, 8'h48, 8'h4c,
         8'h42, 8'h4a, 8'h00};
      logic [2:0] k[9] = '{1, 1, 1, 1, 2, 3, 4, 4, 0};
      for (int i = 0; i < 9; i++)
      begin
         wr(mo(4), m[i]);
         rdchk(mo(4), {5'h00, k[i], m[i]});
      end
      wr(vl(4), 8'h5a);
      wr(vl(4) + VALUE_HIGH_OFS, 8'ha5);
      rdchk(vl(4), 16'h005a);
      rdchk(vl(4) + VALUE_HIGH_OFS, 16'h00a5);
   endtask
   // The counter is read only, so the wrap is reached by holding the
   // timer 0 input high, one step per clock, and stopping two past it.
   task automatic s_wrap();
      logic [15:0] a;
      int k;
      wr(ADDR_MASK, 8'h9f);
      wr(ADDR_AMODE, 8'h05);
      wb(1'b0, ADDR_COUNT, 8'h00);
      a = rd[15:0];
      k = 65538 - int'(a);
      @(posedge clock);
      t0 <= 1'b1;
      repeat (k) @(posedge clock);
      t0 <= 1'b0;
      rdchk(ADDR_COUNT, 16'h0002);
      rdchk(ADDR_CONTROL, 16'h00c0);
      irq_is(1'b1);
      wr(ADDR_CONTROL, 8'hc0);
      rdchk(ADDR_CONTROL, 16'h0040);
      irq_is(1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      s_capture();
      s_compare();
      s_idle_run();
      s_edges();
      s_rates();
      s_modes();
      s_wrap();
      final_report();
   end
   initial
   begin
      repeat (90000) @(posedge clock);
      n_errors++;
      final_report();
   end
endmodule
